// file: src/pdmac_pkg.sv
package pdmac_pkg;
	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_CH    = 8;
	localparam int REQ_LINES = 128;
	localparam int SEL_W     = 7;
	localparam int LEN_W     = 10;
	localparam int ADDR_W    = 7;

	// ************************************************************
	// Register map, word index on the register port
	// ************************************************************
	localparam logic [2:0] SLOT_CTL = 3'h0;
	localparam logic [2:0] SLOT_SEL = 3'h1;
	localparam logic [2:0] SLOT_PRI = 3'h2;
	localparam logic [2:0] SLOT_SEC = 3'h3;
	localparam logic [2:0] SLOT_PER = 3'h4;
	localparam logic [2:0] SLOT_LEN = 3'h5;
	localparam logic [6:0] REG_COLL = 7'h40;
	localparam logic [6:0] REG_STAT = 7'h41;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int FORCE_POS = 15;
	localparam int OM_ONESHOT_BIT = 0;
	localparam int OM_PINGPONG_BIT = 1;
	localparam logic [15:0] CTL_WMASK = 16'hf833;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] IND_MASK  = 16'h07ff;
	localparam logic [1:0] AS_POSTINC = 2'h0;
	localparam logic [1:0] AS_FIXED   = 2'h1;
	localparam logic [1:0] AS_PERIND  = 2'h2;

	// Channel control word, bit 15 down to bit 0
	typedef struct packed {
		logic       channel_enable;
		logic       byte_size;
		logic       ram_to_per;
		logic       half_irq;
		logic       blank_peripheral_write;
		logic [4:0] rsv_hi;
		logic [1:0] address_scheme;
		logic [1:0] rsv_lo;
		logic [1:0] op_mode;
	} pdmac_ctl_t;

	// One request on a transfer bus
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic        rd;
		logic        wr;
		logic        byte_size;
	} pdmac_req_t;
endpackage

// file: src/pdmac_arb.sv
`timescale 1ns/1ps
module pdmac_arb #(
	parameter int N = 8
) (
	input  wire logic [N-1:0]         req,
	output logic      [N-1:0]         grant,
	output logic      [$clog2(N)-1:0] idx,
	output logic                      valid
);
	localparam int IW = $clog2(N);

	generate
		if (N < 2) begin : g_bad
			$error("pdmac_arb needs at least two requesters");
		end
	endgenerate

	// Fixed priority, channel 0 highest; low numbers may starve others
	always_comb begin
		grant = '0;
		idx   = '0;
		valid = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				grant    = '0;
				grant[i] = 1'b1;
				idx      = IW'(i);
				valid    = 1'b1;
			end
		end
	end
endmodule

// file: src/pdmac_chan.sv
`timescale 1ns/1ps
module pdmac_chan (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire pdmac_pkg::pdmac_ctl_t    ctl,
	input  wire logic [15:0]              pri_start,
	input  wire logic [15:0]              sec_start,
	input  wire logic [pdmac_pkg::LEN_W-1:0] last_idx,
	input  wire logic [15:0]              ind_addr,
	input  wire logic                     req_hit,
	input  wire logic                     force_set,
	input  wire logic                     grant,
	input  wire logic                     xfer_done,
	output logic                          pending,
	output logic                          force_bit,
	output logic                          active,
	output logic [15:0]                   ram_addr,
	output logic                          block_irq
);
	logic pend_reg, pend_next, force_reg, force_next;
	logic pp_reg, pp_next, stop_reg, stop_next, en_d_reg;
	logic irq_reg, irq_next;
	logic [pdmac_pkg::LEN_W-1:0] cnt_reg, cnt_next;
	logic [15:0] ptr_reg, ptr_next, base;
	logic start, last, half_pt, ping, once;

	assign start   = ctl.channel_enable & ~en_d_reg;
	assign active  = ctl.channel_enable & ~stop_reg;
	assign last    = cnt_reg == last_idx;              // see R20
	assign half_pt = cnt_reg == (last_idx >> 1);
	assign ping    = ctl.op_mode[pdmac_pkg::OM_PINGPONG_BIT];
	assign once    = ctl.op_mode[pdmac_pkg::OM_ONESHOT_BIT];
	assign pending   = pend_reg & active;              // see R2
	assign force_bit = force_reg;
	assign block_irq = irq_reg;

	// Buffer base and scheme give the RAM address
	always_comb begin
		base = pp_reg ? sec_start : pri_start;          // see R11
		case (ctl.address_scheme)
		pdmac_pkg::AS_POSTINC: ram_addr = base + ptr_reg; // see R7
		pdmac_pkg::AS_PERIND: ram_addr = (base & ~pdmac_pkg::IND_MASK) |
			(ind_addr & pdmac_pkg::IND_MASK);           // see R15
		default: ram_addr = base;                       // see R7
		endcase
	end

	// Block progress; a new request beats a grant in the same cycle
	always_comb begin
		pend_next  = pend_reg;
		force_next = force_reg;
		cnt_next   = cnt_reg;
		ptr_next   = ptr_reg;
		pp_next    = pp_reg;
		stop_next  = stop_reg;
		irq_next   = 1'b0;
		if (grant)
			pend_next = 1'b0;
		if (active && (req_hit || force_set))
			pend_next = 1'b1;                           // see R16
		if (xfer_done)
			force_next = 1'b0;
		if (force_set)
			force_next = 1'b1;                          // see R18
		if (start) begin
			cnt_next  = '0;
			ptr_next  = '0;
			pp_next   = 1'b0;                           // see R23
			stop_next = 1'b0;
		end else if (xfer_done) begin
			irq_next = ctl.half_irq ? half_pt : last;   // see R5
			if (last) begin
				cnt_next = '0;
				ptr_next = '0;                          // see R10
				if (ping)
					pp_next = ~pp_reg;                  // see R11
				if (once && (!ping || pp_reg))
					stop_next = 1'b1;                   // see R9
			end else begin
				cnt_next = cnt_reg + 1'b1;
				ptr_next = ptr_reg + (ctl.byte_size ? 16'h0001 : 16'h0002); // see R22
			end
		end
	end

	// Channel state registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pend_reg  <= 1'b0;
			force_reg <= 1'b0;
			cnt_reg   <= '0;
			ptr_reg   <= 16'h0000;
			pp_reg    <= 1'b0;
			stop_reg  <= 1'b0;
			en_d_reg  <= 1'b0;
			irq_reg   <= 1'b0;
		end else begin
			pend_reg  <= pend_next;
			force_reg <= force_next;
			cnt_reg   <= cnt_next;
			ptr_reg   <= ptr_next;
			pp_reg    <= pp_next;
			stop_reg  <= stop_next;
			en_d_reg  <= ctl.channel_enable;
			irq_reg   <= irq_next;
		end
	end

	len_wrap_a: assert property (@(posedge core_clk) disable iff (rst) // see R20
		(xfer_done && last && !start) |=> cnt_reg == '0)
		else $error("count did not wrap at block end");
endmodule

// file: src/pdmac_top.sv
// Notes on behaviour
// R1: Eight identical channels, each with its own registers.
// R2: Enable bit 15 makes a channel active; cleared keeps it idle.
// R3: Size bit 14 chooses byte moves when set, word moves when clear.
// R4: Direction set reads RAM, writes peripheral; clear does the reverse.
// R5: Half select raises the block request at half block, else at end.
// R6: Blank write with direction clear also writes zero to the peripheral.
// R7: Scheme 00 post-increment, 01 fixed, 10 peripheral indirect, 11 reserved.
// R8: Mode 00 continuous, 01 one-shot, 10 continuous ping-pong, 11 one-shot pp.
// R9: One-shot stops after one block; in one-shot ping-pong the code stops after two blocks, primary then secondary.
// R10: Continuous reloads the buffer start after each block.
// R11: Ping-pong alternates primary and secondary starts per block.
// R12: Each channel raises its own request at block end or half point.
// R13: Transfers use dedicated buses, never the processor's.
// R14: Any channel can be triggered by any peripheral request number.
// R15: Peripheral indirect mixes peripheral address bits into RAM address.
// R16: Blocks start on the selected request or on software force.
// R17: Per channel control, select, two starts, peripheral, 10-bit length.
// R18: Force makes one transfer, hardware clears it, zero writes do not.
// R19: Seven-bit select chooses one of 128 request lines.
// R20: Transfers per block equal length value plus one.
// R21: Write collisions set per-channel flags that software only clears.
// R22: Post-increment adds one after a byte, two after a word.
// R23: Ping-pong starts on the primary buffer after reset or enable.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module pdmac_top (
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	input  wire logic [pdmac_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]                  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [15:0]                  reg_rdata,
	input  wire logic [pdmac_pkg::REQ_LINES-1:0] dreq,
	input  wire logic [15:0]                  per_ind_addr,
	input  wire logic [15:0]                  per_rdata,
	input  wire logic [15:0]                  ram_rdata,
	input  wire logic                         cpu_per_wr,
	input  wire logic [15:0]                  cpu_per_addr,
	input  wire logic                         cpu_ram_wr,
	input  wire logic [15:0]                  cpu_ram_addr,
	output pdmac_pkg::pdmac_req_t             per_req,
	output pdmac_pkg::pdmac_req_t             ram_req,
	output logic      [pdmac_pkg::NUM_CH-1:0] block_irq
);
	localparam int N = pdmac_pkg::NUM_CH;

	typedef enum {ENG_IDLE, ENG_READ, ENG_LATCH, ENG_WRITE} pdmac_eng_t;

	// ************************************************************
	// Register file
	// ************************************************************
	pdmac_pkg::pdmac_ctl_t ctl_reg [N];
	pdmac_pkg::pdmac_ctl_t ctl_next [N];
	logic [pdmac_pkg::SEL_W-1:0] sel_reg [N];
	logic [pdmac_pkg::SEL_W-1:0] sel_next [N];
	logic [15:0] pri_reg [N];
	logic [15:0] pri_next [N];
	logic [15:0] sec_reg [N];
	logic [15:0] sec_next [N];
	logic [15:0] pad_reg [N];
	logic [15:0] pad_next [N];
	logic [pdmac_pkg::LEN_W-1:0] len_reg [N];
	logic [pdmac_pkg::LEN_W-1:0] len_next [N];
	logic [15:0] coll_reg, coll_next, rdata_next;
	logic [N-1:0] pcol_ev, xcol_ev, force_set, force_vec, active_vec;
	logic [N-1:0] pend_vec, arb_grant, chan_grant, xfer_done;
	logic [15:0] ram_addr_vec [N];
	logic [2:0] arb_idx, rch;
	logic arb_valid, ch_wr;

	// ************************************************************
	// Transfer engine state
	// ************************************************************
	pdmac_eng_t state_reg, state_next;
	logic [2:0]  ch_reg, ch_next;
	logic [15:0] per_addr_reg, per_addr_next, ram_addr_reg, ram_addr_next;
	logic [15:0] data_reg, data_next, src_data;
	logic dir_reg, dir_next, bsize_reg, bsize_next, null_reg, null_next;

	assign rch   = reg_addr[5:3];
	assign ch_wr = reg_wr & ~reg_addr[6];

	// Software writes; the control word has reserved bits masked, select and length keep only their low bits
	always_comb begin
		for (int c = 0; c < N; c++) begin
			ctl_next[c] = ctl_reg[c];
			sel_next[c] = sel_reg[c];
			pri_next[c] = pri_reg[c];
			sec_next[c] = sec_reg[c];
			pad_next[c] = pad_reg[c];
			len_next[c] = len_reg[c];
			force_set[c] = ch_wr && rch == 3'(c) &&
				reg_addr[2:0] == pdmac_pkg::SLOT_SEL &&
				reg_wdata[pdmac_pkg::FORCE_POS];        // see R18
			if (ch_wr && rch == 3'(c)) begin             // see R17
				case (reg_addr[2:0])
				pdmac_pkg::SLOT_CTL: ctl_next[c] = pdmac_pkg::pdmac_ctl_t'(
					reg_wdata & pdmac_pkg::CTL_WMASK);   // see R8
				pdmac_pkg::SLOT_SEL:
					sel_next[c] = reg_wdata[pdmac_pkg::SEL_W-1:0]; // see R19
				pdmac_pkg::SLOT_PRI: pri_next[c] = reg_wdata;
				pdmac_pkg::SLOT_SEC: sec_next[c] = reg_wdata;
				pdmac_pkg::SLOT_PER: pad_next[c] = reg_wdata;
				pdmac_pkg::SLOT_LEN:
					len_next[c] = reg_wdata[pdmac_pkg::LEN_W-1:0];
				default: ;
				endcase
			end
		end
	end

	// Collision flags: writing zero clears, a new event still wins
	always_comb begin
		coll_next = coll_reg;
		if (reg_wr && reg_addr == pdmac_pkg::REG_COLL)
			coll_next = coll_reg & reg_wdata;
		coll_next = coll_next | {pcol_ev, xcol_ev};     // see R21
	end

	// Read data stands one cycle after the strobe, zero elsewhere
	always_comb begin
		rdata_next = 16'h0000;
		if (reg_rd) begin
			if (reg_addr == pdmac_pkg::REG_COLL)
				rdata_next = coll_reg;
			else if (reg_addr == pdmac_pkg::REG_STAT)
				rdata_next = {5'h00, ch_reg, active_vec};
			else if (!reg_addr[6]) begin
				case (reg_addr[2:0])
				pdmac_pkg::SLOT_CTL: rdata_next = ctl_reg[rch];
				pdmac_pkg::SLOT_SEL:
					rdata_next = {force_vec[rch], 8'h00, sel_reg[rch]};
				pdmac_pkg::SLOT_PRI: rdata_next = pri_reg[rch];
				pdmac_pkg::SLOT_SEC: rdata_next = sec_reg[rch];
				pdmac_pkg::SLOT_PER: rdata_next = pad_reg[rch];
				pdmac_pkg::SLOT_LEN: rdata_next = {6'h00, len_reg[rch]};
				default: rdata_next = 16'h0000;
				endcase
			end
		end
	end

	// Register file storage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < N; c++) begin
				ctl_reg[c] <= pdmac_pkg::pdmac_ctl_t'(pdmac_pkg::REG_RESET);
				sel_reg[c] <= '0;
				pri_reg[c] <= pdmac_pkg::REG_RESET;
				sec_reg[c] <= pdmac_pkg::REG_RESET;
				pad_reg[c] <= pdmac_pkg::REG_RESET;
				len_reg[c] <= '0;
			end
			coll_reg  <= pdmac_pkg::REG_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			for (int c = 0; c < N; c++) begin
				ctl_reg[c] <= ctl_next[c];
				sel_reg[c] <= sel_next[c];
				pri_reg[c] <= pri_next[c];
				sec_reg[c] <= sec_next[c];
				pad_reg[c] <= pad_next[c];
				len_reg[c] <= len_next[c];
			end
			coll_reg  <= coll_next;
			reg_rdata <= rdata_next;
		end
	end

	// ************************************************************
	// Channels and arbitration
	// ************************************************************
	genvar gc;
	generate
		for (gc = 0; gc < N; gc++) begin : g_ch
			pdmac_chan u_chan (
				.core_clk  (core_clk),
				.rst       (rst),
				.ctl       (ctl_reg[gc]),
				.pri_start (pri_reg[gc]),
				.sec_start (sec_reg[gc]),
				.last_idx  (len_reg[gc]),
				.ind_addr  (per_ind_addr),
				.req_hit   (dreq[sel_reg[gc]]),   // see R14
				.force_set (force_set[gc]),
				.grant     (chan_grant[gc]),
				.xfer_done (xfer_done[gc]),
				.pending   (pend_vec[gc]),
				.force_bit (force_vec[gc]),
				.active    (active_vec[gc]),
				.ram_addr  (ram_addr_vec[gc]),
				.block_irq (block_irq[gc])         // see R12
			);
			assign xfer_done[gc] = state_reg == ENG_WRITE && ch_reg == 3'(gc);
		end
	endgenerate

	pdmac_arb #(.N(N)) u_arb (
		.req   (pend_vec),
		.grant (arb_grant),
		.idx   (arb_idx),
		.valid (arb_valid)
	);

	assign chan_grant = (state_reg == ENG_IDLE) ? arb_grant : '0; // see R1

	// ************************************************************
	// Transfer engine on its own peripheral and RAM buses
	// ************************************************************
	assign src_data = dir_reg ? ram_rdata : per_rdata;

	// Four steps per move: pick, read, capture, write
	always_comb begin
		state_next    = state_reg;
		ch_next       = ch_reg;
		per_addr_next = per_addr_reg;
		ram_addr_next = ram_addr_reg;
		dir_next      = dir_reg;
		bsize_next    = bsize_reg;
		null_next     = null_reg;
		data_next     = data_reg;
		case (state_reg)
		ENG_IDLE: if (arb_valid) begin
			ch_next       = arb_idx;
			per_addr_next = pad_reg[arb_idx];
			ram_addr_next = ram_addr_vec[arb_idx];
			dir_next      = ctl_reg[arb_idx].ram_to_per;    // see R4
			bsize_next    = ctl_reg[arb_idx].byte_size;     // see R3
			null_next     = ctl_reg[arb_idx].blank_peripheral_write &
				~ctl_reg[arb_idx].ram_to_per;               // see R6
			state_next    = ENG_READ;
		end
		ENG_READ:  state_next = ENG_LATCH;
		ENG_LATCH: begin
			data_next  = bsize_reg ? {8'h00, src_data[7:0]} : src_data; // see R3
			state_next = ENG_WRITE;
		end
		ENG_WRITE: state_next = ENG_IDLE;
		default:   state_next = ENG_IDLE;
		endcase
	end

	// Engine registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg    <= ENG_IDLE;
			ch_reg       <= 3'h0;
			per_addr_reg <= 16'h0000;
			ram_addr_reg <= 16'h0000;
			dir_reg      <= 1'b0;
			bsize_reg    <= 1'b0;
			null_reg     <= 1'b0;
			data_reg     <= 16'h0000;
		end else begin
			state_reg    <= state_next;
			ch_reg       <= ch_next;
			per_addr_reg <= per_addr_next;
			ram_addr_reg <= ram_addr_next;
			dir_reg      <= dir_next;
			bsize_reg    <= bsize_next;
			null_reg     <= null_next;
			data_reg     <= data_next;
		end
	end

	// Bus strobes from state; the processor buses are never touched
	always_comb begin
		per_req.addr      = per_addr_reg;                  // see R13
		per_req.data      = null_reg ? 16'h0000 : data_reg;
		per_req.rd        = state_reg == ENG_READ && !dir_reg;
		per_req.wr        = state_reg == ENG_WRITE && (dir_reg || null_reg);
		per_req.byte_size = bsize_reg;
		ram_req.addr      = ram_addr_reg;
		ram_req.data      = data_reg;
		ram_req.rd        = state_reg == ENG_READ && dir_reg;
		ram_req.wr        = state_reg == ENG_WRITE && !dir_reg;
		ram_req.byte_size = bsize_reg;
	end

	// A processor write to the same target in our write cycle collides
	always_comb begin
		pcol_ev = '0;
		xcol_ev = '0;
		pcol_ev[ch_reg] = per_req.wr && cpu_per_wr &&
			cpu_per_addr == per_addr_reg;                  // see R21
		xcol_ev[ch_reg] = ram_req.wr && cpu_ram_wr &&
			cpu_ram_addr == ram_addr_reg;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence move_read_s;
		state_reg == ENG_READ ##1 state_reg == ENG_LATCH;
	endsequence
	sequence move_write_s;
		state_reg == ENG_WRITE ##1 state_reg == ENG_IDLE;
	endsequence

	move_steps_a: assert property (move_read_s |=> move_write_s) // see R13
		else $error("move steps out of order");
	grant_one_a: assert property ($onehot0(chan_grant)) // see R1
		else $error("more than one channel granted");
	grant_enabled_a: assert property ( // see R2
		(state_reg == ENG_IDLE && arb_valid) |->
		ctl_reg[arb_idx].channel_enable)
		else $error("disabled channel granted");
	byte_lane_a: assert property ( // see R3
		(ram_req.wr && ram_req.byte_size) |-> ram_req.data[15:8] == 8'h00)
		else $error("byte move carries upper byte");
	dir_path_a: assert property ( // see R4
		state_reg == ENG_READ |-> (per_req.rd != ram_req.rd))
		else $error("read on wrong bus");
	null_write_a: assert property ( // see R6
		(ram_req.wr && null_reg) |-> (per_req.wr && per_req.data == 16'h0000))
		else $error("blank peripheral write missing");
	force_clear_a: assert property ( // see R18
		$fell(|force_vec) |-> $past(state_reg) == ENG_WRITE)
		else $error("force cleared without a transfer");
	irq_cause_a: assert property ( // see R12
		|block_irq |-> $past(state_reg) == ENG_WRITE)
		else $error("block request without a transfer");
	coll_set_a: assert property ( // see R21
		pcol_ev != '0 |=> (coll_reg[15:8] & $past(pcol_ev)) == $past(pcol_ev))
		else $error("collision flag not set");
endmodule

// file: bench/pdmac_far.sv
`timescale 1ns/1ps
// ************************************************************
// Peripheral registers and RAM as seen from the transfer buses
// ************************************************************
module pdmac_far (
	input  wire logic                  core_clk,
	input  wire pdmac_pkg::pdmac_req_t per_req,
	input  wire pdmac_pkg::pdmac_req_t ram_req,
	output logic      [15:0]           per_rdata,
	output logic      [15:0]           ram_rdata
);
	// Read data only in the cycle after the strobe; at other times the
	// lines flip each cycle, so a late sample cannot match by chance
	initial begin
		per_rdata = 16'h0000;
		ram_rdata = 16'h0000;
	end
	always @(posedge core_clk) begin
		per_rdata <= per_req.rd ? (per_req.addr ^ 16'hc3a5) : ~per_rdata;
		ram_rdata <= ram_req.rd ? (ram_req.addr ^ 16'hc3a5) : ~ram_rdata;
	end
endmodule

// file: bench/pdmac_top_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	$display("unexpected %s exp %h got %h", nm, ex, got); errors++; end end
module pdmac_top_test;
	logic                            core_clk = 1'b0;
	logic                            rst = 1'b1;
	logic [pdmac_pkg::ADDR_W-1:0]    reg_addr = 7'h00;
	logic [15:0]                     reg_wdata = 16'h0000;
	logic                            reg_wr = 1'b0;
	logic                            reg_rd = 1'b0;
	logic [15:0]                     reg_rdata, per_rdata, ram_rdata;
	logic [pdmac_pkg::REQ_LINES-1:0] dreq = 128'h0;
	logic [15:0]                     per_ind_addr = 16'h0000;
	logic                            cpu_ram_wr = 1'b0;
	logic                            cpu_per_wr = 1'b0;
	logic                            rd_seen = 1'b0;
	logic [15:0]                     cpu_ram_addr = 16'h0000;
	logic [15:0]                     cpu_per_addr = 16'h0000;
	logic                            coll_en = 1'b0;
	pdmac_pkg::pdmac_req_t           per_req, ram_req;
	logic [pdmac_pkg::NUM_CH-1:0]    block_irq;
	logic [15:0]                     ram_a[$], ram_d[$], per_a[$], per_d[$];
	logic [15:0]                     pri, sec, pad, ea, d;
	logic [6:0]                      line;
	logic [2:0]                      ch = 3'h0;
	logic [1:0]                      md, sc;
	logic                            bs, dir, hf, nw;
	int                              errors = 0;
	int                              n_tests = 0;
	int                              cycles = 0;
	int                              irq_n, irq_x, len, n, nx, ni;

	pdmac_top i_pdmac_top (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dreq(dreq),
		.per_ind_addr(per_ind_addr), .per_rdata(per_rdata),
		.ram_rdata(ram_rdata), .cpu_per_wr(cpu_per_wr),
		.cpu_per_addr(cpu_per_addr),
		.cpu_ram_wr(cpu_ram_wr), .cpu_ram_addr(cpu_ram_addr),
		.per_req(per_req), .ram_req(ram_req), .block_irq(block_irq));
	pdmac_far i_pdmac_far (.core_clk(core_clk), .per_req(per_req),
		.ram_req(ram_req), .per_rdata(per_rdata), .ram_rdata(ram_rdata));

	always #25 core_clk = ~core_clk;

	// ************************************************************
	// Bus monitor, collision maker and watchdog
	// ************************************************************
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			$display("unexpected cycles exp %0d got %0d", 5999, cycles);
			tally_and_finish();
		end
		if (!rst) begin
			if (ram_req.rd === 1'b1 || ram_req.wr === 1'b1) ram_a.push_back(ram_req.addr);
			if (ram_req.wr === 1'b1) ram_d.push_back(ram_req.data);
			if (per_req.wr === 1'b1) per_a.push_back(per_req.addr);
			if (per_req.wr === 1'b1) per_d.push_back(per_req.data);
			// Unknown request bits count as raised, so they cannot hide
			irq_n += int'(block_irq[ch] !== 1'b0);
			irq_x += 8 - $countones(~block_irq) - int'(block_irq[ch] !== 1'b0);
		end
	end
	// Processor writes land in the move's write cycle, two edges after
	// the read strobe; both buses are hit so both flag halves are tried
	always @(posedge core_clk) begin
		rd_seen <= ram_req.rd | per_req.rd;
		cpu_ram_wr <= coll_en & rd_seen;
		cpu_per_wr <= coll_en & rd_seen;
		cpu_ram_addr <= ram_req.addr;
		cpu_per_addr <= per_req.addr;
	end

	// ************************************************************
	// Register port tasks and expectations
	// ************************************************************
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic chk_reg(input string nm, input logic [6:0] a,
		input logic [15:0] ex);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(nm, ex, reg_rdata)
	endtask
	task automatic trig(input logic [6:0] l);
		@(posedge core_clk);
		dreq[l] <= 1'b1;
		@(posedge core_clk);
		dreq[l] <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic flush();
		ram_a.delete(); ram_d.delete(); per_a.delete(); per_d.delete();
		irq_n = 0;
		irq_x = 0;
	endtask
	function automatic logic [6:0] ra(logic [2:0] c, logic [2:0] s);
		return {1'b0, c, s};
	endfunction
	function automatic logic [15:0] far_data(logic [15:0] a, logic b);
		return b ? ((a ^ 16'hc3a5) & 16'h00ff) : (a ^ 16'hc3a5);
	endfunction
	// RAM address of move k: buffer by block parity, offset by scheme
	function automatic logic [15:0] exp_addr(logic [1:0] m, logic [1:0] s,
		logic b, int k, int nn, logic [15:0] p, logic [15:0] q, logic [15:0] ia);
		logic [15:0] base;
		base = (m[1] && ((k / nn) % 2 == 1)) ? q : p;
		if (s == pdmac_pkg::AS_POSTINC) return base + 16'((k % nn) * (b ? 1 : 2));
		if (s == pdmac_pkg::AS_PERIND)
			return (base & ~pdmac_pkg::IND_MASK) | (ia & pdmac_pkg::IND_MASK);
		return base;
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		void'($urandom(32'h392d));
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		ch = 3'($urandom % 8);
		for (int s = 0; s < 6; s++) chk_reg("reset", ra(ch, 3'(s)), pdmac_pkg::REG_RESET);
		wr(ra(ch, pdmac_pkg::SLOT_CTL), 16'h77ff);
		chk_reg("ctl mask", ra(ch, pdmac_pkg::SLOT_CTL), 16'h7033);
		wr(ra(ch, pdmac_pkg::SLOT_LEN), 16'hffff);
		chk_reg("len mask", ra(ch, pdmac_pkg::SLOT_LEN), 16'h03ff);
		wr(ra(ch, pdmac_pkg::SLOT_SEL), 16'h7fff);
		chk_reg("sel mask", ra(ch, pdmac_pkg::SLOT_SEL), 16'h007f);
		wr(7'h7f, 16'hffff);
		chk_reg("unmapped", 7'h7f, 16'h0000);
		wr(ra(ch, pdmac_pkg::SLOT_CTL), 16'h0000);
		$display("test registers done, errors %0d", errors);
		// Every mode and scheme twice, with direction from the loop count and random size and options
		for (int i = 0; i < 8; i++) begin
			ch = 3'($urandom % 8);
			md = 2'(i);
			sc = 2'(i / 2);
			dir = 1'(i ^ (i >> 1));
			{bs, hf, nw} = 3'($urandom);
			len = i % 3;
			n = len + 1;
			line = 7'($urandom);
			{pri, sec, pad} = {16'($urandom), 16'($urandom), 16'($urandom)};
			per_ind_addr <= 16'($urandom);
			wr(ra(ch, pdmac_pkg::SLOT_SEL), {9'h000, line});
			wr(ra(ch, pdmac_pkg::SLOT_PRI), pri);
			wr(ra(ch, pdmac_pkg::SLOT_SEC), sec);
			wr(ra(ch, pdmac_pkg::SLOT_PER), pad);
			wr(ra(ch, pdmac_pkg::SLOT_LEN), 16'(len));
			flush();
			wr(ra(ch, pdmac_pkg::SLOT_CTL), {1'b1, bs, dir, hf, nw, 5'h00, sc, 2'h0, md});
			repeat (7) trig(line);
			nx = md[0] ? ((md[1] ? 2 : 1) * n) : 7;
			`CHK("moves", nx, ram_a.size())
			`CHK("per writes", (dir | nw) ? nx : 0, per_a.size())
			ni = 0;
			for (int k = 0; k < nx; k++) begin
				ea = exp_addr(md, sc, bs, k, n, pri, sec, per_ind_addr);
				`CHK("ram addr", ea, ram_a[k])
				d = dir ? per_d[k] : ram_d[k];
				`CHK("data", far_data(dir ? ea : pad, bs), d)
				if (!dir && nw) `CHK("blank data", 16'h0000, per_d[k]);
				if (dir || nw) `CHK("per addr", pad, per_a[k]);
				ni += hf ? int'(k % n == len / 2) : int'(k % n == len);
			end
			`CHK("irq count", ni, irq_n)
			`CHK("stray irq", 0, irq_x)
			wr(ra(ch, pdmac_pkg::SLOT_CTL), 16'h0000);
			$display("test mode %0d scheme %0d done, errors %0d", md, sc, errors);
		end
		// Force on an idle channel is kept, and a zero write leaves it set
		flush();
		wr(ra(ch, pdmac_pkg::SLOT_SEL), {1'b1, 8'h00, line});
		wr(ra(ch, pdmac_pkg::SLOT_SEL), {9'h000, line});
		chk_reg("force kept", ra(ch, pdmac_pkg::SLOT_SEL), {1'b1, 8'h00, line});
		`CHK("idle moves", 0, ram_a.size())
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		chk_reg("sel reset", ra(ch, pdmac_pkg::SLOT_SEL), 16'h0000);
		wr(ra(ch, pdmac_pkg::SLOT_LEN), 16'h0005);
		wr(ra(ch, pdmac_pkg::SLOT_CTL), 16'h8001);
		flush();
		wr(ra(ch, pdmac_pkg::SLOT_SEL), {1'b1, 8'h00, line});
		repeat (10) @(posedge core_clk);
		`CHK("forced moves", 1, ram_a.size())
		chk_reg("force clear", ra(ch, pdmac_pkg::SLOT_SEL), {9'h000, line});
		chk_reg("status", pdmac_pkg::REG_STAT, {5'h00, ch, 8'h01 << ch});
		$display("test force done, errors %0d", errors);
		// Processor writing the same RAM word and peripheral register
		wr(ra(ch, pdmac_pkg::SLOT_CTL), 16'h8801);
		coll_en <= 1'b1;
		trig(line);
		coll_en <= 1'b0;
		chk_reg("collision", pdmac_pkg::REG_COLL, 16'h0101 << ch);
		wr(pdmac_pkg::REG_COLL, 16'h0000);
		chk_reg("coll clear", pdmac_pkg::REG_COLL, 16'h0000);
		$display("test collision done, errors %0d", errors);
		tally_and_finish();
	end
endmodule
